// >>> hw/vref_ctrl_pkg.sv
package vref_ctrl_pkg;

    // Register map, byte addresses on the slave port
    localparam logic [7:0] CTRL_ADDR        = 8'h00;
    localparam logic [7:0] CTRL_RESET       = 8'h00;

    // Field positions in the control word
    localparam int         EN_BIT           = 7;
    localparam int         READY_BIT        = 6;
    localparam int         TS_EN_BIT        = 5;
    localparam int         TS_RNG_BIT       = 4;
    localparam int         CMP_GAIN_LSB     = 2;
    localparam int         CNV_GAIN_LSB     = 0;

    // Buffer gain codes
    localparam logic [1:0] GAIN_OFF         = 2'h0;
    localparam logic [1:0] GAIN_X1          = 2'h1;
    localparam logic [1:0] GAIN_X2          = 2'h2;
    localparam logic [1:0] GAIN_X4          = 2'h3;

    // Reference settling time, rounded up to whole clocks
    localparam int         CLK_PERIOD_PS    = 25000;
    localparam int         SETTLE_TIME_NS   = 20000;
    localparam int         SETTLE_CYCLES    = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// >>> hw/settle_if.sv
`timescale 1ns/1ps
`default_nettype none

interface settle_if;
    logic start;
    logic ready;

    modport ctrl  (output start, input ready);
    modport timer (input start, output ready);
endinterface

`default_nettype wire

// >>> hw/ref_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ref_settle_timer #(
    parameter int CYCLES = vref_ctrl_pkg::SETTLE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    settle_if.timer   stl
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          ready;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Dropping the enable restarts the settling wait from zero
        if (!stl.start) begin
            st_nxt.count = '0;
            st_nxt.ready = 1'b0;
        end else if (st_r.count != CW'(CYCLES)) begin
            st_nxt.count = st_r.count + CW'(1);
        end else begin
            st_nxt.ready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stl.ready = st_r.ready;
endmodule

`default_nettype wire

// >>> hw/voltage_ref_temp_sense_control.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bit 7 is a writable reference enable.
// - Bit 6 is read-only ready: 1 when reference usable, else 0.
// - On the high-voltage variant the ready flag always reads 1.
// - Bit 5 is a writable temperature sensor enable.
// - Bit 4 selects temperature range: 1 high (four drops), 0 low.
// - Bits 3-2 set comparator buffer gain: 11 4x, 10 2x, 01 1x, 00 off.
// - Bits 1-0 set converter buffer gain with the same coding.
// - On the standard variant, ready stays low after enable until the circuits have settled.
module voltage_ref_temp_sense_control #(
    parameter bit HIGH_VOLTAGE_VARIANT = 1'b0,
    parameter int SETTLE_CYCLES        = vref_ctrl_pkg::SETTLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             ref_enable,
    output logic             ref_ready_flag,
    output logic             temp_sense_enable,
    output logic             temp_range_select,
    output logic      [1:0]  comparator_ref_gain,
    output logic      [1:0]  converter_ref_gain,
    output logic             comp_buf_on,
    output logic      [2:0]  comp_gain_mult,
    output logic             conv_buf_on,
    output logic      [2:0]  conv_gain_mult
);
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        en;
        logic        ready;
        logic        ts_en;
        logic        ts_rng;
        logic [1:0]  cmp_gain;
        logic [1:0]  cnv_gain;
        logic        cmp_on;
        logic [2:0]  cmp_mult;
        logic        cnv_on;
        logic [2:0]  cnv_mult;
    } ctrl_state_t;

    // One-hot multiplier {4x,2x,1x}; all zero means buffer off
    function automatic logic [2:0] gain_mult(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            vref_ctrl_pkg::GAIN_X4: m = 3'h4;
            vref_ctrl_pkg::GAIN_X2: m = 3'h2;
            vref_ctrl_pkg::GAIN_X1: m = 3'h1;
            default:                m = 3'h0;
        endcase
        return m;
    endfunction

    // Any code but off powers the buffer
    function automatic logic buf_on(input logic [1:0] code);
        return code != vref_ctrl_pkg::GAIN_OFF;
    endfunction

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;
    logic        hit;
    logic        wr_take;
    logic [7:0]  ctrl_word;

    settle_if stl ();

    ref_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk   (clk),
        .rst_b (rst_b),
        .stl   (stl)
    );

    assign stl.start = st_r.en;
    assign hit       = (address == vref_ctrl_pkg::CTRL_ADDR);
    // Write lands at the edge where waitrequest is seen low
    assign wr_take   = write && !st_r.waitreq && hit && byteenable[0];
    assign ctrl_word = {st_r.en, st_r.ready, st_r.ts_en, st_r.ts_rng, st_r.cmp_gain, st_r.cnv_gain};

    always_comb begin
        st_nxt = st_r;
        // One wait state per access; unmapped reads return zero
        if ((read || write) && st_r.waitreq) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata   = hit ? {24'h0000_00, ctrl_word} : 32'h0000_0000;
        end else begin
            st_nxt.waitreq = 1'b1;
        end
        if (wr_take) begin
            st_nxt.en       = writedata[vref_ctrl_pkg::EN_BIT];
            st_nxt.ts_en    = writedata[vref_ctrl_pkg::TS_EN_BIT];
            st_nxt.ts_rng   = writedata[vref_ctrl_pkg::TS_RNG_BIT];
            st_nxt.cmp_gain = writedata[vref_ctrl_pkg::CMP_GAIN_LSB +: 2];
            st_nxt.cnv_gain = writedata[vref_ctrl_pkg::CNV_GAIN_LSB +: 2];
        end
        // Ready is never taken from writedata
        st_nxt.ready    = HIGH_VOLTAGE_VARIANT ? 1'b1 : (stl.ready && st_nxt.en);
        st_nxt.cmp_mult = gain_mult(st_nxt.cmp_gain);
        st_nxt.cmp_on   = buf_on(st_nxt.cmp_gain);
        st_nxt.cnv_mult = gain_mult(st_nxt.cnv_gain);
        st_nxt.cnv_on   = buf_on(st_nxt.cnv_gain);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r         <= '0;
            st_r.waitreq <= 1'b1;
            st_r.ready   <= HIGH_VOLTAGE_VARIANT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata            = st_r.rdata;
    assign waitrequest         = st_r.waitreq;
    assign ref_enable          = st_r.en;
    assign ref_ready_flag      = st_r.ready;
    assign temp_sense_enable   = st_r.ts_en;
    assign temp_range_select   = st_r.ts_rng;
    assign comparator_ref_gain = st_r.cmp_gain;
    assign converter_ref_gain  = st_r.cnv_gain;
    assign comp_buf_on         = st_r.cmp_on;
    assign comp_gain_mult      = st_r.cmp_mult;
    assign conv_buf_on         = st_r.cnv_on;
    assign conv_gain_mult      = st_r.cnv_mult;

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_take |=> ref_enable == $past(writedata[7]))
        else $error("reference enable did not follow the write");

    a_ready_off: assert property (@(posedge clk) disable iff (!rst_b)
        (!ref_enable && !HIGH_VOLTAGE_VARIANT) |-> !ref_ready_flag)
        else $error("ready set while reference disabled");

    a_ready_const: assert property (@(posedge clk) disable iff (!rst_b)
        HIGH_VOLTAGE_VARIANT |-> ref_ready_flag)
        else $error("ready not constant on high-voltage variant");

    a_ready_settle: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(ref_enable) && !HIGH_VOLTAGE_VARIANT) |-> !ref_ready_flag [*8])
        else $error("ready rose before settling");

    a_ready_bound: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(ref_enable) && !HIGH_VOLTAGE_VARIANT) |-> ##[1:900] (ref_ready_flag || !ref_enable))
        else $error("ready did not rise after settling");

    a_temp_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_take |=> temp_sense_enable == $past(writedata[5]) && temp_range_select == $past(writedata[4]))
        else $error("temperature bits did not follow the write");

    a_comp_decode: assert property (@(posedge clk) disable iff (!rst_b)
        comp_buf_on == (comparator_ref_gain != 2'h0) && comp_gain_mult[2] == (comparator_ref_gain == 2'h3))
        else $error("comparator gain decode wrong");

    a_conv_decode: assert property (@(posedge clk) disable iff (!rst_b)
        wr_take |=> conv_buf_on == ($past(writedata[1:0]) != 2'h0)
            && conv_gain_mult[0] == ($past(writedata[1:0]) == 2'h1))
        else $error("converter gain decode wrong");

    a_ready_ro: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_take && writedata[6] && !writedata[7] && !HIGH_VOLTAGE_VARIANT) |=> !ref_ready_flag)
        else $error("write reached the ready flag");

    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_b)
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("slave did not answer in one wait state");

    a_wait_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !(read || write) |=> waitrequest)
        else $error("waitrequest low without a request");

    a_read_back: assert property (@(posedge clk) disable iff (!rst_b)
        (read && waitrequest && address == vref_ctrl_pkg::CTRL_ADDR) |=>
            readdata[7] == $past(ref_enable) && readdata[6] == $past(ref_ready_flag)
            && readdata[5] == $past(temp_sense_enable) && readdata[4] == $past(temp_range_select)
            && readdata[3:2] == $past(comparator_ref_gain) && readdata[1:0] == $past(converter_ref_gain)
            && readdata[31:8] == 24'h0000_00)
        else $error("read data differ from the control fields");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (read && waitrequest && address != vref_ctrl_pkg::CTRL_ADDR) |=> readdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_fields_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !wr_take |=> $stable(ref_enable) && $stable(temp_sense_enable) && $stable(temp_range_select)
            && $stable(comparator_ref_gain) && $stable(converter_ref_gain))
        else $error("control field changed without an accepted write");

    a_comp_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_take |=> comparator_ref_gain == $past(writedata[3:2]) && converter_ref_gain == $past(writedata[1:0]))
        else $error("gain fields did not follow the write");

    a_comp_mult: assert property (@(posedge clk) disable iff (!rst_b)
        comp_gain_mult == ((comparator_ref_gain == 2'h3) ? 3'h4 : (comparator_ref_gain == 2'h2) ? 3'h2
            : (comparator_ref_gain == 2'h1) ? 3'h1 : 3'h0))
        else $error("comparator multiplier wrong");

    a_conv_mult: assert property (@(posedge clk) disable iff (!rst_b)
        conv_gain_mult == ((converter_ref_gain == 2'h3) ? 3'h4 : (converter_ref_gain == 2'h2) ? 3'h2
            : (converter_ref_gain == 2'h1) ? 3'h1 : 3'h0))
        else $error("converter multiplier wrong");

    a_ready_wait: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(ref_ready_flag) && !HIGH_VOLTAGE_VARIANT) |-> $past(ref_enable, 8))
        else $error("ready rose too soon after enable");

    a_ready_hv_read: assert property (@(posedge clk) disable iff (!rst_b)
        (HIGH_VOLTAGE_VARIANT && read && waitrequest && address == vref_ctrl_pkg::CTRL_ADDR) |=> readdata[6])
        else $error("high-voltage variant read ready as zero");
endmodule

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int SETTLE = 10;
    // 200 us of 25 ns clocks
    localparam int TS_WAIT = 8000;
    logic        clk         = 1'b0;
    logic        rst_b       = 1'b0;
    logic [7:0]  address     = 8'h00;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [31:0] writedata   = 32'h0000_0000;
    logic [3:0]  byteenable  = 4'h0;
    logic [31:0] readdata;
    logic        waitrequest, ref_enable, ref_ready_flag, temp_sense_enable, temp_range_select;
    logic        comp_buf_on, conv_buf_on, hv_ready;
    logic [1:0]  comparator_ref_gain, converter_ref_gain;
    logic [2:0]  comp_gain_mult, conv_gain_mult;
    logic [31:0] rd;
    int          mismatches  = 0;
    int          tests_run   = 0;
    int          n;
    wire  [7:0]  pins = {ref_enable, ref_ready_flag, temp_sense_enable, temp_range_select,
                         comparator_ref_gain, converter_ref_gain};
    wire  [7:0]  bufs = {comp_buf_on, comp_gain_mult, conv_buf_on, conv_gain_mult};

    voltage_ref_temp_sense_control #(.HIGH_VOLTAGE_VARIANT(1'b0), .SETTLE_CYCLES(SETTLE)) i_voltage_ref_temp_sense_control (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .ref_enable(ref_enable),
        .ref_ready_flag(ref_ready_flag), .temp_sense_enable(temp_sense_enable),
        .temp_range_select(temp_range_select), .comparator_ref_gain(comparator_ref_gain),
        .converter_ref_gain(converter_ref_gain), .comp_buf_on(comp_buf_on), .comp_gain_mult(comp_gain_mult),
        .conv_buf_on(conv_buf_on), .conv_gain_mult(conv_gain_mult));

    // Second copy only to watch the ready flag of the high-voltage variant
    voltage_ref_temp_sense_control #(.HIGH_VOLTAGE_VARIANT(1'b1), .SETTLE_CYCLES(SETTLE)) i_voltage_ref_temp_sense_control_hv (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(), .waitrequest(), .ref_enable(), .ref_ready_flag(hv_ready),
        .temp_sense_enable(), .temp_range_select(), .comparator_ref_gain(), .converter_ref_gain(),
        .comp_buf_on(), .comp_gain_mult(), .conv_buf_on(), .conv_gain_mult());

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k >= 50) check(32'h0000_0000, 32'h0000_0001);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        access(1'b0, a, 8'h00, 4'hF);
        check(rd, {24'h00_0000, exp});
    endtask

    function automatic logic [3:0] dec(input logic [1:0] g);
        dec = (g == 2'h0) ? 4'h0 : {1'b1, 3'h1 << (g - 2'h1)};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd_check(8'h00, 8'h00);
        check({31'h0, hv_ready}, 32'h0000_0001);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            access(1'b1, 8'h00, {2'b01, 2'(g), 2'(g), 2'(3 - g)}, 4'h1);
            rd_check(8'h00, {2'b00, 2'(g), 2'(g), 2'(3 - g)});
            @(negedge clk);
            check({24'h0, pins}, {24'h0, 2'b00, 2'(g), 2'(g), 2'(3 - g)});
            check({24'h0, bufs}, {24'h0, dec(2'(g)), dec(2'(3 - g))});
        end
        $display("test gain codes done");
        access(1'b1, 8'h00, 8'hFF, 4'h0);
        access(1'b1, 8'h04, 8'hFF, 4'hF);
        rd_check(8'h04, 8'h00);
        rd_check(8'h00, 8'h3C);
        $display("test refused writes done");
        access(1'b1, 8'h00, 8'h80, 4'h1);
        rd_check(8'h00, 8'h80);
        n = 0;
        while (ref_ready_flag !== 1'b1 && n < SETTLE + 20) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, (n >= SETTLE - 1 && n <= SETTLE + 4)}, 32'h0000_0001);
        rd_check(8'h00, 8'hC0);
        check({31'h0, hv_ready}, 32'h0000_0001);
        access(1'b1, 8'h00, 8'h00, 4'h1);
        rd_check(8'h00, 8'h00);
        $display("test settle done");
        // Register reads stand in for sensor conversions
        access(1'b1, 8'h00, 8'hA1, 4'h1);
        repeat (TS_WAIT) @(posedge clk);
        rd_check(8'h00, 8'hE1);
        repeat (TS_WAIT) @(posedge clk);
        rd_check(8'h00, 8'hE1);
        access(1'b1, 8'h00, 8'h00, 4'h1);
        rd_check(8'h00, 8'h00);
        $display("test sensor waits done");
        access(1'b1, 8'h00, 8'hBF, 4'h1);
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        check({23'h0, waitrequest, pins}, 32'h0000_0100);
        check({31'h0, hv_ready}, 32'h0000_0001);
        @(posedge clk);
        rst_b <= 1'b1;
        rd_check(8'h00, 8'h00);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
